// File: pkg/tle_pkg.sv
// package: register map, field positions, timing and state types of the irq unit
package tle_pkg;
  // register indexes, byte address is four times the index
  localparam logic [9:0] IDX_CENTRAL = 10'h0e6;
  localparam logic [9:0] IDX_EDGE    = 10'h0f2;
  localparam logic [9:0] IDX_PEND    = 10'h0f3;
  localparam logic [9:0] IDX_MASK    = 10'h0f4;
  localparam logic [9:0] IDX_PRIO    = 10'h0f5;
  localparam logic [9:0] IDX_VCTL    = 10'h0f6;
  localparam logic [9:0] IDX_NEST    = 10'h0f7;
  // reset values
  localparam logic [7:0] CENTRAL_RST = 8'h87;
  localparam logic [7:0] EDGE_RST    = 8'h00;
  localparam logic [7:0] PEND_RST    = 8'h00;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] PRIO_RST    = 8'hff;
  localparam logic [7:0] VCTL_RST    = 8'h06;
  localparam logic [7:0] NEST_RST    = 8'h00;
  // field positions
  localparam int CIC_CNT   = 7;
  localparam int CIC_TLP   = 6;
  localparam int CIC_TLM   = 5;
  localparam int CIC_GIE   = 4;
  localparam int CIC_ARB   = 3;
  localparam int VC_EDGE   = 3;
  localparam int VC_SRC    = 2;
  localparam int VC_A0     = 1;
  localparam int VC_WAIT   = 0;
  localparam int NC_LOCK   = 7;
  localparam int EDGE_D1   = 7;
  localparam logic [7:0] EDGE_WMASK = 8'h7f;
  // timing in core clock cycles
  localparam logic [2:0] SAMPLE_PERIOD = 3'h5;
  localparam logic [4:0] RESOLVE_CYC   = 5'h06;
  localparam logic [4:0] ENTRY_BASE    = 5'h12;
  localparam logic [4:0] ENTRY_STACK   = 5'h02;
  localparam logic [4:0] ENTRY_SEG     = 5'h02;
  localparam logic [4:0] ENTRY_WAKE    = 5'h01;
  localparam logic [2:0] LOWEST_PRIO   = 3'h7;
  // value is arbitrary
  localparam logic [7:0] TL_VECTOR     = 8'h00;

  typedef enum logic [1:0] {ARB_IDLE, ARB_RESOLVE, ARB_GRANT, ARB_ENTRY} tle_arb_t;

  // status signals from the cpu core
  typedef struct packed {
    logic no_write;
    logic instr_done;
    logic iret;
    logic ei;
    logic di;
    logic wfi;
    logic stack_rf;
    logic seg_push;
  } tle_core_in_t;

  // request towards the cpu core
  typedef struct packed {
    logic       req;
    logic       abort;
    logic       isr_start;
    logic       tl_active;
    logic [7:0] vector;
  } tle_core_out_t;

  typedef struct packed {
    logic       counter_enable;
    logic       top_level_pending;
    logic       top_level_mask_enable;
    logic       global_int_enable;
    logic       arbitration_mode_select;
    logic [2:0] current_priority;
    logic [7:0] ext_edge;
    logic [7:0] ext_pend;
    logic [7:0] ext_mask;
    logic [7:0] ext_prio;
    logic [7:0] ext_vctl;
    logic       top_level_lock;
    logic [6:0] hold_level;
    logic [7:0] pin_prev;
    logic       nmi_prev;
    logic [2:0] div;
    tle_arb_t   arb;
    logic [4:0] cnt;
    logic [4:0] entry_len;
    logic       win_tl;
    logic [2:0] win_ch;
    logic [2:0] win_p;
    logic       tl_active;
    logic       irq_req;
    logic       abort;
    logic       isr_start;
    logic [7:0] vector;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
  } tle_state_t;

endpackage : tle_pkg

// File: rtl/tle_irq_unit.sv
// top-level and external interrupt unit with apb register slave
`timescale 1ns/10ps
module tle_irq_unit (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // interrupt sources
  input  wire logic                   nmi_pin,
  input  wire logic                   wdg_end_count,
  input  wire logic [7:0]             ext_pin,
  // cpu core
  input  wire tle_pkg::tle_core_in_t  core_in,
  output tle_pkg::tle_core_out_t      core_out,
  // side controls
  output logic                        timer_enable,
  output logic                        wait_pin_enable
);

  tle_pkg::tle_state_t q;
  tle_pkg::tle_state_t d;

  logic       access;
  logic       wr_en;
  logic [9:0] idx;
  logic [8:0] rd;
  logic       tick;
  logic [7:0] ev_pin;
  logic [7:0] ext_ev;
  logic       tl_ev;
  logic       tl_req;
  logic       ext_req;
  logic       go;
  logic       best_ok;
  logic [2:0] best_ch;
  logic [2:0] best_p;
  logic [2:0] ch_p;
  logic [2:0] pop_lvl;
  logic       pop_any;
  logic [4:0] len;

  // priority of one external channel from its pair field
  function automatic logic [2:0] ch_prio(input logic [7:0] pr, input logic [2:0] ch);
    ch_prio = {pr[{ch[2:1], 1'b1}], pr[{ch[2:1], 1'b0}], ch[0]};
  endfunction : ch_prio

  // register read decode, msb marks a mapped index
  function automatic logic [8:0] reg_read(input logic [9:0] i, input tle_pkg::tle_state_t s);
    case (i)
      tle_pkg::IDX_CENTRAL: reg_read = {1'b1, s.counter_enable, s.top_level_pending,
                                        s.top_level_mask_enable, s.global_int_enable,
                                        s.arbitration_mode_select, s.current_priority};
      tle_pkg::IDX_EDGE:    reg_read = {1'b1, s.ext_edge};
      tle_pkg::IDX_PEND:    reg_read = {1'b1, s.ext_pend};
      tle_pkg::IDX_MASK:    reg_read = {1'b1, s.ext_mask};
      tle_pkg::IDX_PRIO:    reg_read = {1'b1, s.ext_prio};
      tle_pkg::IDX_VCTL:    reg_read = {1'b1, s.ext_vctl};
      tle_pkg::IDX_NEST:    reg_read = {1'b1, s.top_level_lock, s.hold_level};
      default:              reg_read = 9'h000;
    endcase
  endfunction : reg_read

  // bus decode
  assign access = psel & penable;
  assign idx    = paddr[11:2];
  assign rd     = (paddr[1:0] == 2'h0) ? reg_read(idx, q) : 9'h000;
  assign wr_en  = access & q.pready & pwrite & ~q.pslverr;

  // sampling divider
  assign tick = (q.div == tle_pkg::SAMPLE_PERIOD - 3'h1);

  // edge detection, sources keep one cycle per level
  assign ev_pin = (ext_pin & ~q.pin_prev & q.ext_edge) |
                  (~ext_pin & q.pin_prev & ~q.ext_edge);
  assign ext_ev = {ev_pin[7:1],
                   q.ext_vctl[tle_pkg::VC_A0] ? ev_pin[0] : wdg_end_count};
  assign tl_ev  = q.ext_vctl[tle_pkg::VC_SRC] ?
                  (q.ext_vctl[tle_pkg::VC_EDGE] ? (nmi_pin & ~q.nmi_prev)
                                                : (~nmi_pin & q.nmi_prev)) :
                  wdg_end_count;

  // top-level request gating
  assign tl_req = q.top_level_pending & ~q.tl_active &
                  (q.top_level_lock |
                   (q.top_level_mask_enable & q.global_int_enable));
  assign ext_req = best_ok & ~q.tl_active;
  assign go      = core_in.no_write | core_in.instr_done;

  // entry length from stack place, segment push and wait state
  assign len = tle_pkg::ENTRY_BASE +
               (core_in.stack_rf ? tle_pkg::ENTRY_STACK : 5'h00) +
               (core_in.seg_push ? tle_pkg::ENTRY_SEG : 5'h00) +
               (core_in.wfi ? tle_pkg::ENTRY_WAKE : 5'h00);

  // best enabled external channel
  always_comb
  begin
    best_ok = 1'b0;
    best_ch = 3'h0;
    best_p  = tle_pkg::LOWEST_PRIO;
    ch_p    = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      ch_p = ch_prio(q.ext_prio, 3'(i));
      if (q.ext_mask[i] && q.ext_pend[i] && q.global_int_enable &&
          ch_p != tle_pkg::LOWEST_PRIO && ch_p < q.current_priority &&
          (!best_ok || ch_p < best_p))
      begin
        best_ok = 1'b1;
        best_ch = 3'(i);
        best_p  = ch_p;
      end
    end
  end

  // most recently held level, the lowest set bit
  always_comb
  begin
    pop_any = 1'b0;
    pop_lvl = 3'h0;
    for (int i = 6; i >= 0; i--)
    begin
      if (q.hold_level[i])
      begin
        pop_any = 1'b1;
        pop_lvl = 3'(i);
      end
    end
  end

  // next state
  always_comb
  begin
    d           = q;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    d.abort     = 1'b0;
    d.isr_start = 1'b0;
    d.div       = tick ? 3'h0 : q.div + 3'h1;
    d.pin_prev  = ext_pin;
    d.nmi_prev  = nmi_pin;
    // apb access phase: one wait state, then answer
    if (access && !q.pready)
    begin
      d.pready  = 1'b1;
      d.pslverr = ~rd[8];
      d.prdata  = {24'h00_0000, rd[7:0]};
    end
    // register writes
    if (wr_en)
    begin
      case (idx)
        tle_pkg::IDX_CENTRAL:
        begin
          d.counter_enable          = pwdata[tle_pkg::CIC_CNT];
          d.top_level_pending       = q.top_level_pending | pwdata[tle_pkg::CIC_TLP];
          d.top_level_mask_enable   = pwdata[tle_pkg::CIC_TLM];
          d.global_int_enable       = pwdata[tle_pkg::CIC_GIE];
          d.arbitration_mode_select = pwdata[tle_pkg::CIC_ARB];
          d.current_priority        = pwdata[2:0];
        end
        tle_pkg::IDX_EDGE: d.ext_edge = pwdata[7:0] & tle_pkg::EDGE_WMASK;
        tle_pkg::IDX_PEND: d.ext_pend = pwdata[7:0];
        tle_pkg::IDX_MASK: d.ext_mask = pwdata[7:0];
        tle_pkg::IDX_PRIO: d.ext_prio = pwdata[7:0];
        tle_pkg::IDX_VCTL: d.ext_vctl = pwdata[7:0];
        tle_pkg::IDX_NEST:
        begin
          d.top_level_lock = q.top_level_lock | pwdata[tle_pkg::NC_LOCK];
          d.hold_level     = pwdata[6:0];
        end
        default: d.prdata = q.prdata;
      endcase
    end
    // arbitration and entry sequencing
    case (q.arb)
      tle_pkg::ARB_IDLE:
      begin
        if (tick && (tl_req || ext_req))
        begin
          d.arb    = tle_pkg::ARB_RESOLVE;
          d.cnt    = tle_pkg::RESOLVE_CYC - 5'h01;
          d.win_tl = tl_req;
          d.win_ch = best_ch;
          d.win_p  = tl_req ? 3'h0 : best_p;
          d.vector = tl_req ? tle_pkg::TL_VECTOR
                            : {q.ext_vctl[7:4], best_ch, 1'b0};
        end
      end
      tle_pkg::ARB_RESOLVE:
      begin
        if (q.cnt == 5'h00)
        begin
          d.arb     = tle_pkg::ARB_GRANT;
          d.irq_req = 1'b1;
        end
        else
        begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      tle_pkg::ARB_GRANT:
      begin
        if (go)
        begin
          d.irq_req   = 1'b0;
          d.abort     = core_in.no_write;
          d.arb       = tle_pkg::ARB_ENTRY;
          d.entry_len = len;
          d.cnt       = len - 5'h01;
          if (q.win_tl)
          begin
            d.top_level_pending = 1'b0;
            d.tl_active         = 1'b1;
          end
          else
          begin
            d.ext_pend[q.win_ch] = 1'b0;
            d.global_int_enable  = 1'b0;
            if (q.arbitration_mode_select)
            begin
              if (q.current_priority != tle_pkg::LOWEST_PRIO)
              begin
                d.hold_level[q.current_priority] = 1'b1;
              end
              d.current_priority = q.win_p;
            end
          end
        end
      end
      tle_pkg::ARB_ENTRY:
      begin
        if (q.cnt == 5'h00)
        begin
          d.isr_start = 1'b1;
          d.arb       = tle_pkg::ARB_IDLE;
        end
        else
        begin
          d.cnt = q.cnt - 5'h01;
        end
      end
      default: d.arb = tle_pkg::ARB_IDLE;
    endcase
    // return from a routine
    if (core_in.iret)
    begin
      if (q.tl_active)
      begin
        d.tl_active = 1'b0;
      end
      else
      begin
        d.global_int_enable = 1'b1;
        if (q.arbitration_mode_select)
        begin
          d.current_priority = pop_any ? pop_lvl : tle_pkg::LOWEST_PRIO;
          if (pop_any)
          begin
            d.hold_level[pop_lvl] = 1'b0;
          end
        end
      end
    end
    // enable and disable instructions
    if (core_in.ei)
    begin
      d.global_int_enable = 1'b1;
    end
    if (core_in.di)
    begin
      d.global_int_enable = 1'b0;
    end
    // hardware sets win over any clear
    d.ext_pend = d.ext_pend | ext_ev;
    if (tl_ev)
    begin
      d.top_level_pending = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '{counter_enable:          tle_pkg::CENTRAL_RST[tle_pkg::CIC_CNT],
             top_level_pending:       tle_pkg::CENTRAL_RST[tle_pkg::CIC_TLP],
             top_level_mask_enable:   tle_pkg::CENTRAL_RST[tle_pkg::CIC_TLM],
             global_int_enable:       tle_pkg::CENTRAL_RST[tle_pkg::CIC_GIE],
             arbitration_mode_select: tle_pkg::CENTRAL_RST[tle_pkg::CIC_ARB],
             current_priority:        tle_pkg::CENTRAL_RST[2:0],
             ext_edge:   tle_pkg::EDGE_RST,
             ext_pend:   tle_pkg::PEND_RST,
             ext_mask:   tle_pkg::MASK_RST,
             ext_prio:   tle_pkg::PRIO_RST,
             ext_vctl:   tle_pkg::VCTL_RST,
             top_level_lock: tle_pkg::NEST_RST[tle_pkg::NC_LOCK],
             hold_level: tle_pkg::NEST_RST[6:0],
             pin_prev:   8'h00,
             nmi_prev:   1'b0,
             div:        3'h0,
             arb:        tle_pkg::ARB_IDLE,
             cnt:        5'h00,
             entry_len:  5'h00,
             win_tl:     1'b0,
             win_ch:     3'h0,
             win_p:      3'h0,
             tl_active:  1'b0,
             irq_req:    1'b0,
             abort:      1'b0,
             isr_start:  1'b0,
             vector:     8'h00,
             pready:     1'b0,
             pslverr:    1'b0,
             prdata:     32'h0000_0000};
    end
    else
    begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign prdata             = q.prdata;
  assign pready             = q.pready;
  assign pslverr            = q.pslverr;
  assign core_out.req       = q.irq_req;
  assign core_out.abort     = q.abort;
  assign core_out.isr_start = q.isr_start;
  assign core_out.tl_active = q.tl_active;
  assign core_out.vector    = q.vector;
  assign timer_enable       = q.counter_enable;
  assign wait_pin_enable    = q.ext_vctl[tle_pkg::VC_WAIT];

  // checks on sequencing and flags
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_resolve_hold;
    (q.arb == tle_pkg::ARB_RESOLVE) [*6];
  endsequence
  sequence s_granted;
    (q.arb == tle_pkg::ARB_GRANT) && q.irq_req;
  endsequence

  property p_resolve_time;
    $rose(q.arb == tle_pkg::ARB_RESOLVE) |-> s_resolve_hold ##1 s_granted;
  endproperty
  a_resolve_time: assert property (p_resolve_time) else $error("resolve not six cycles");

  property p_sample_period;
    tick |=> !tick [*4] ##1 tick;
  endproperty
  a_sample_period: assert property (p_sample_period) else $error("sample period wrong");

  property p_entry_time;
    ($rose(q.arb == tle_pkg::ARB_ENTRY) && q.entry_len == tle_pkg::ENTRY_BASE)
      |-> ##18 q.isr_start;
  endproperty
  a_entry_time: assert property (p_entry_time) else $error("entry not eighteen cycles");

  property p_lock_sticky;
    $past(q.top_level_lock) |-> q.top_level_lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");

  property p_tl_exclusive;
    q.tl_active |-> !q.irq_req && q.arb != tle_pkg::ARB_RESOLVE;
  endproperty
  a_tl_exclusive: assert property (p_tl_exclusive) else $error("top-level preempted");

  property p_tl_keeps_enable;
    (q.arb == tle_pkg::ARB_GRANT && go && q.win_tl && !wr_en &&
     !core_in.ei && !core_in.di && !core_in.iret)
      |=> q.global_int_enable == $past(q.global_int_enable);
  endproperty
  a_tl_keeps_enable: assert property (p_tl_keeps_enable) else $error("tl entry changed enable");

  property p_tl_ack_clear;
    (q.arb == tle_pkg::ARB_GRANT && go && q.win_tl && !tl_ev) |=> !q.top_level_pending;
  endproperty
  a_tl_ack_clear: assert property (p_tl_ack_clear) else $error("tl pending not cleared");

  property p_tl_set;
    tl_ev |=> q.top_level_pending;
  endproperty
  a_tl_set: assert property (p_tl_set) else $error("tl pending not set");

  property p_ext_set;
    (ext_ev != 8'h00) |=> ((q.ext_pend & $past(ext_ev)) == $past(ext_ev));
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext pending not set");

  property p_no_level7;
    ($rose(q.arb == tle_pkg::ARB_RESOLVE) && !q.win_tl)
      |-> q.win_p != tle_pkg::LOWEST_PRIO;
  endproperty
  a_no_level7: assert property (p_no_level7) else $error("level seven granted");

  property p_better_level;
    ($rose(q.arb == tle_pkg::ARB_RESOLVE) && !q.win_tl)
      |-> q.win_p < $past(q.current_priority);
  endproperty
  a_better_level: assert property (p_better_level) else $error("grant not above level");

  property p_d1_clear;
    !q.ext_edge[tle_pkg::EDGE_D1];
  endproperty
  a_d1_clear: assert property (p_d1_clear) else $error("d1 edge bit set");

endmodule : tle_irq_unit

// File: test/tle_core_model.sv
// cpu core model answering grants of the irq unit
`timescale 1ns/10ps
module tle_core_model (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // bench controls: slow core, then iret ei di wfi stack_rf seg_push
  input  wire logic                   slow,
  input  wire logic [5:0]             ctl,
  // unit side
  input  wire tle_pkg::tle_core_out_t core_out,
  output tle_pkg::tle_core_in_t       core_in
);
  logic [1:0] wait_q;

  // cycles spent with a grant offered
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      wait_q <= 2'h0;
    else if (core_out.req)
      wait_q <= wait_q + 2'h1;
    else
      wait_q <= 2'h0;
  end

  // fast core aborts at once, slow core finishes its instruction first
  assign core_in = {~slow, slow & (wait_q == 2'h3), ctl};
endmodule : tle_core_model

// File: test/tb_top.sv
// self-checking bench of the irq unit
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t value mismatch", $time); end end
module tb_top;
  localparam logic [9:0] RC = tle_pkg::IDX_CENTRAL;
  localparam logic [9:0] RE = tle_pkg::IDX_EDGE;
  localparam logic [9:0] RP = tle_pkg::IDX_PEND;
  localparam logic [9:0] RM = tle_pkg::IDX_MASK;
  localparam logic [9:0] RV = tle_pkg::IDX_VCTL;
  localparam logic [9:0] RN = tle_pkg::IDX_NEST;
  localparam logic [7:0] TV = tle_pkg::TL_VECTOR;
  logic                   clock = 1'b0;
  logic                   rstn = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0000_0000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   nmi_pin = 1'b0;
  logic                   wdg_end_count = 1'b0;
  logic                   slow = 1'b0;
  logic [7:0]             ext_pin = 8'h00;
  logic [5:0]             ctl = 6'h00;
  logic                   timer_enable;
  logic                   wait_pin_enable;
  tle_pkg::tle_core_in_t  core_in;
  tle_pkg::tle_core_out_t core_out;
  logic [31:0]            rd;
  logic                   err;
  int                     errors = 0;
  int                     total_checks = 0;
  int                     cyc = 0;

  tle_irq_unit u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_pin(nmi_pin), .wdg_end_count(wdg_end_count),
    .ext_pin(ext_pin), .core_in(core_in), .core_out(core_out),
    .timer_enable(timer_enable), .wait_pin_enable(wait_pin_enable));

  tle_core_model u_core (.clock(clock), .rstn(rstn), .slow(slow), .ctl(ctl),
    .core_out(core_out), .core_in(core_in));

  // clock and hang guard
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] wd);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr

  task automatic rchk(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rd, {24'h00_0000, e})
  endtask : rchk

  // one-cycle core strobe, then back to the level bits
  task automatic pulse(input logic [5:0] v);
    ctl <= v;
    @(posedge clock);
    ctl <= v & 6'h07;
  endtask : pulse

  // wait for a grant and its routine start, checking vector, abort and timing
  task automatic serve(input logic [7:0] vec, input int len, input logic ab,
                       input int lo, input int hi);
    int t;
    int m;
    for (t = 0; t < 80 && core_out.req !== 1'b1; t++)
      @(posedge clock);
    for (; t < 80 && core_out.req === 1'b1; t++)
      @(posedge clock);
    `CHK(core_out.abort, ab)
    `CHK(core_out.vector, vec)
    for (m = 0; m < 80 && core_out.isr_start !== 1'b1; m++)
      @(posedge clock);
    `CHK(m, len)
    `CHK((t + m >= lo) && (t + m <= hi), 1'b1)
  endtask : serve

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rchk(RC, 8'h87);
    rchk(RE, 8'h00);
    rchk(RP, 8'h00);
    `CHK(timer_enable, 1'b1)
    `CHK(wait_pin_enable, 1'b0)
    apb(1'b0, 10'h001, 8'h00);
    `CHK(err, 1'b1)
    pulse(6'h10);
    rchk(RC, 8'h97);
    pulse(6'h08);
    rchk(RC, 8'h87);
    wr(RE, 8'hff);
    rchk(RE, 8'h7f);
    wr(RE, 8'h04);
    ext_pin <= 8'h08;
    repeat (3) @(posedge clock);
    rchk(RP, 8'h00);
    ext_pin <= 8'h00;
    repeat (3) @(posedge clock);
    rchk(RP, 8'h08);
    wr(RC, 8'h97);
    wr(RP, 8'h04);
    repeat (20) @(posedge clock);
    rchk(RP, 8'h04);
    rchk(RC, 8'h97);
    wr(RP, 8'h08);
    wr(RM, 8'h08);
    repeat (20) @(posedge clock);
    rchk(RC, 8'h97);
    wr(RC, 8'h87);
    wr(RP, 8'h10);
    wr(tle_pkg::IDX_PRIO, 8'hc7);
    wr(RM, 8'h14);
    ext_pin <= 8'h04;
    repeat (3) @(posedge clock);
    wr(RC, 8'h97);
    serve(8'h08, 18, 1'b1, 0, 99);
    rchk(RP, 8'h04);
    rchk(RC, 8'h87);
    slow <= 1'b1;
    pulse(6'h27);
    serve(8'h04, 23, 1'b0, 0, 99);
    slow <= 1'b0;
    pulse(6'h20);
    ext_pin <= 8'h00;
    repeat (3) @(posedge clock);
    ext_pin <= 8'h04;
    serve(8'h04, 18, 1'b1, 26, 48);
    pulse(6'h20);
    wr(RV, 8'h0e);
    wr(RC, 8'hb7);
    nmi_pin <= 1'b1;
    serve(TV, 18, 1'b1, 22, 48);
    `CHK(core_out.tl_active, 1'b1)
    rchk(RC, 8'hb7);
    wr(RP, 8'h04);
    repeat (20) @(posedge clock);
    rchk(RP, 8'h04);
    wr(RP, 8'h00);
    wr(RC, 8'ha7);
    pulse(6'h20);
    rchk(RC, 8'ha7);
    `CHK(core_out.tl_active, 1'b0)
    wr(RV, 8'h0b);
    wdg_end_count <= 1'b1;
    @(posedge clock);
    wdg_end_count <= 1'b0;
    repeat (20) @(posedge clock);
    rchk(RC, 8'he7);
    `CHK(wait_pin_enable, 1'b1)
    wr(RN, 8'h80);
    serve(TV, 18, 1'b1, 0, 99);
    pulse(6'h20);
    wr(RN, 8'h00);
    rchk(RN, 8'h80);
    rchk(RC, 8'ha7);
    wr(RC, 8'he7);
    serve(TV, 18, 1'b1, 0, 99);
    pulse(6'h20);
    // nested mode: level pushed on entry, popped on return
    wr(RC, 8'h1b);
    wr(RP, 8'h04);
    serve(8'h04, 18, 1'b1, 0, 99);
    rchk(RC, 8'h0a);
    rchk(RN, 8'h88);
    `CHK(timer_enable, 1'b0)
    pulse(6'h20);
    rchk(RC, 8'h1b);
    rchk(RN, 8'h80);
    tally_and_finish();
  end
endmodule : tb_top
